//--- hw/snb_consts.svh
// register offsets, bit positions, reset values and frame counts of the serial port
// assumes a 32-bit classic Wishbone bus with byte addresses
`ifndef SNB_CONSTS_SVH
`define SNB_CONSTS_SVH
`define SNB_ADR_CTRL1 5'h00
`define SNB_ADR_BAUD 5'h04
`define SNB_ADR_CTRL3 5'h08
`define SNB_ADR_DATA 5'h0C
`define SNB_ADR_STAT 5'h10
`define SNB_C1_TE 0
`define SNB_C1_RE 1
`define SNB_C1_M 2
`define SNB_C1_LOOPBACK_ENABLE 3
`define SNB_C1_RECEIVER_SOURCE_SEL 4
`define SNB_C3_T8 0
`define SNB_C3_SINGLE_WIRE_TX_DIRECTION 1
`define SNB_C3_EDGIE 2
`define SNB_C3_R8 3
`define SNB_ST_TDRE 0
`define SNB_ST_TC 1
`define SNB_ST_RDRF 2
`define SNB_ST_IDLE 3
`define SNB_ST_OR 4
`define SNB_ST_FE 5
`define SNB_ST_EDGE 6
`define SNB_BAUD_RST 16'h0082
`define SNB_OSR 4'hF
`define SNB_MID 4'h7
`define SNB_BITS8 4'hA
`define SNB_BITS9 4'hB
`endif

//--- hw/snb_pkg.sv
// types shared by the serial port: stop-mode code, bus carriers and the state record
// assumes nothing beyond a SystemVerilog tool
package snb_pkg;
  typedef enum logic [1:0] {
    SNB_RUN,
    SNB_STOP_LIGHT,
    SNB_STOP_MID,
    SNB_STOP_DEEP
  } snb_stop_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } snb_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } snb_wb_rsp_t;

  typedef struct packed {
    logic te;
    logic re;
    logic m;
    logic loopback_enable;
    logic receiver_source_sel;
    logic t8;
    logic single_wire_tx_direction;
    logic edgie;
    logic [15:0] baud;
    logic [15:0] pre;
    logic [7:0] tbuf;
    logic tdre;
    logic tbusy;
    logic [10:0] tsh;
    logic [3:0] tbits;
    logic [3:0] tph;
    logic rprev;
    logic rbusy;
    logic [8:0] rsh;
    logic [3:0] rbits;
    logic [3:0] rph;
    logic [8:0] rdata;
    logic rdrf;
    logic ovr;
    logic fe;
    logic idle;
    logic idle_arm;
    logic [3:0] icnt;
    logic [3:0] iph;
    logic edge_f;
    logic ack;
    logic [31:0] rd;
  } snb_state_t;
endpackage : snb_pkg

//--- hw/snb_serial_port.sv
// serial port with 8/9-bit characters, stop-mode behaviour, loop and single-wire modes
// assumes classic Wishbone from a 20 MHz clk_i, synchronous pins and a stop-mode code from the power controller
// Function
// - control bit m selects 9-bit characters for transmitter and receiver
// - outgoing ninth bit and received ninth bit live in control register three
// - ninth transmit bit is copied into the shifter with the buffered byte
// - ninth transmit bit stays until software writes another value
// - every stop mode halts all shifting, and all sampling except the receive edge detector in lightest stop
// - two deepest stop modes lose all registers, lightest keeps them
// - receive edge detector works in lightest stop, wakes when enabled
// - after lightest stop the port resumes from retained state
// - loop mode feeds transmitter output to receiver, receive pin released
// - single-wire mode joins receiver to transmitter output and transmit pin
// - single-wire, direction zero: transmit pin is an input to receiver
// - single-wire, direction one: transmitter drives transmit pin
// - single-wire mode receiver sees every character the port sends only with direction one
// - idle character time is 10 bits in 8-bit mode, 11 in 9-bit
`include "snb_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module snb_serial_port
  import snb_pkg::*;
#(
  parameter logic [15:0] BAUD_RST = `SNB_BAUD_RST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire snb_wb_req_t wb_req_i,
  output snb_wb_rsp_t wb_rsp_o,
  input wire snb_stop_t stop_mode_i,
  input wire logic rx_i,
  input wire logic tx_i,
  output logic tx_o,
  output logic tx_oe_n_o,
  output logic rx_released_o,
  output logic wake_o
);

  snb_state_t q, d, rst_v;
  logic tick, tx_line, rin, nine, frame_end;
  logic wr, rd_data, run, light, lose;
  logic bus_req, rx_fall;
  logic [3:0] nbits;
  logic [31:0] rdv;

  always_comb begin
    rst_v = '0;
    rst_v.baud = BAUD_RST;
    rst_v.tdre = 1'b1;
    rst_v.rprev = 1'b1;
  end

  // stop-mode decode: only light stop keeps the edge detector alive and the registers intact
  always_comb begin
    run = 1'b0;
    light = 1'b0;
    lose = 1'b0;
    unique case (stop_mode_i)
      SNB_RUN: begin
        run = 1'b1;
      end
      SNB_STOP_LIGHT: begin
        light = 1'b1;
      end
      SNB_STOP_MID: begin
        lose = 1'b1;
      end
      SNB_STOP_DEEP: begin
        lose = 1'b1;
      end
    endcase
  end

  assign nine = q.m;
  assign nbits = nine ? `SNB_BITS9 : `SNB_BITS8;
  assign tick = (q.baud != 16'h0000) && (q.pre == 16'h0000);
  assign tx_line = q.tbusy ? q.tsh[0] : 1'b1;

  // receiver source: pin in full duplex, own output in loop and in single-wire direction one, shared pin in single-wire direction zero
  always_comb begin
    if (!q.loopback_enable) begin
      rin = rx_i;
    end else if (!q.receiver_source_sel) begin
      rin = tx_line;
    end else if (q.single_wire_tx_direction) begin
      rin = tx_line;
    end else begin
      rin = tx_i;
    end
  end

  assign tx_o = tx_line;
  assign tx_oe_n_o = q.loopback_enable && q.receiver_source_sel && !q.single_wire_tx_direction;
  assign rx_released_o = q.loopback_enable;
  assign wake_o = light && q.edge_f && q.edgie;
  // one falling-edge term shared by start detection and the wake edge flag
  assign rx_fall = q.rprev && !rin;

  assign bus_req = wb_req_i.cyc && wb_req_i.stb;
  // effects land on the edge that samples ack, so a held request is never applied twice
  assign wr = bus_req && wb_req_i.we && q.ack && wb_req_i.sel[0];
  assign rd_data = bus_req && !wb_req_i.we && q.ack && (wb_req_i.adr == `SNB_ADR_DATA);
  assign frame_end = q.rbusy && tick && (q.rph == `SNB_MID) && (q.rbits == nbits - 4'h1);

  always_comb begin
    rdv = 32'h0000_0000;
    unique case (wb_req_i.adr)
      `SNB_ADR_CTRL1: begin
        rdv[`SNB_C1_TE] = q.te;
        rdv[`SNB_C1_RE] = q.re;
        rdv[`SNB_C1_M] = q.m;
        rdv[`SNB_C1_LOOPBACK_ENABLE] = q.loopback_enable;
        rdv[`SNB_C1_RECEIVER_SOURCE_SEL] = q.receiver_source_sel;
      end
      `SNB_ADR_BAUD: begin
        rdv[15:0] = q.baud;
      end
      `SNB_ADR_CTRL3: begin
        rdv[`SNB_C3_T8] = q.t8;
        rdv[`SNB_C3_SINGLE_WIRE_TX_DIRECTION] = q.single_wire_tx_direction;
        rdv[`SNB_C3_EDGIE] = q.edgie;
        rdv[`SNB_C3_R8] = q.rdata[8];
      end
      `SNB_ADR_DATA: begin
        rdv[7:0] = q.rdata[7:0];
      end
      `SNB_ADR_STAT: begin
        rdv[`SNB_ST_TDRE] = q.tdre;
        rdv[`SNB_ST_TC] = q.tdre && !q.tbusy;
        rdv[`SNB_ST_RDRF] = q.rdrf;
        rdv[`SNB_ST_IDLE] = q.idle;
        rdv[`SNB_ST_OR] = q.ovr;
        rdv[`SNB_ST_FE] = q.fe;
        rdv[`SNB_ST_EDGE] = q.edge_f;
      end
      default: begin
        rdv = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    d = q;
    // bus answers while running and in light stop, not in the two deeper stops; writes and side effects only while running
    d.ack = bus_req && !q.ack;
    if (bus_req && !q.ack) begin
      d.rd = rdv;
    end

    if (run) begin
      // a zero divisor parks the prescaler so no tick can slip out
      if (tick) begin
        d.pre = q.baud - 16'h0001;
      end else if (q.baud == 16'h0000) begin
        d.pre = 16'h0000;
      end else begin
        d.pre = q.pre - 16'h0001;
      end

      // register writes
      if (wr) begin
        unique case (wb_req_i.adr)
          `SNB_ADR_CTRL1: begin
            d.te = wb_req_i.dat[`SNB_C1_TE];
            d.re = wb_req_i.dat[`SNB_C1_RE];
            d.m = wb_req_i.dat[`SNB_C1_M];
            d.loopback_enable = wb_req_i.dat[`SNB_C1_LOOPBACK_ENABLE];
            d.receiver_source_sel = wb_req_i.dat[`SNB_C1_RECEIVER_SOURCE_SEL];
          end
          `SNB_ADR_BAUD: begin
            d.baud[7:0] = wb_req_i.dat[7:0];
            if (wb_req_i.sel[1]) begin
              d.baud[15:8] = wb_req_i.dat[15:8];
            end
          end
          `SNB_ADR_CTRL3: begin
            d.t8 = wb_req_i.dat[`SNB_C3_T8];
            d.single_wire_tx_direction = wb_req_i.dat[`SNB_C3_SINGLE_WIRE_TX_DIRECTION];
            d.edgie = wb_req_i.dat[`SNB_C3_EDGIE];
          end
          `SNB_ADR_DATA: begin
            d.tbuf = wb_req_i.dat[7:0];
            d.tdre = 1'b0;
          end
          `SNB_ADR_STAT: begin
            if (wb_req_i.dat[`SNB_ST_OR]) begin
              d.ovr = 1'b0;
            end
            if (wb_req_i.dat[`SNB_ST_FE]) begin
              d.fe = 1'b0;
            end
            if (wb_req_i.dat[`SNB_ST_EDGE]) begin
              d.edge_f = 1'b0;
            end
          end
          default: begin
            d.te = q.te;
          end
        endcase
      end
      if (rd_data) begin
        d.rdrf = 1'b0;
        d.idle = 1'b0;
      end

      // transmitter: buffer moves to shifter together with the held ninth bit
      if (!q.tbusy && !q.tdre && q.te) begin
        d.tsh = {1'b1, (nine ? q.t8 : 1'b1), q.tbuf, 1'b0};
        d.tbusy = 1'b1;
        d.tdre = 1'b1;
        d.tbits = 4'h0;
        d.tph = 4'h0;
      end else if (q.tbusy && tick) begin
        d.tph = q.tph + 4'h1;
        if (q.tph == `SNB_OSR) begin
          d.tsh = {1'b1, q.tsh[10:1]};
          d.tbits = q.tbits + 4'h1;
          if (q.tbits == nbits - 4'h1) begin
            d.tbusy = 1'b0;
          end
        end
      end

      // receiver: start on falling edge, sample each bit at mid-point
      if (!q.rbusy) begin
        if (q.re && rx_fall) begin
          d.rbusy = 1'b1;
          d.rbits = 4'h0;
          d.rph = 4'h0;
        end
      end else if (tick) begin
        d.rph = q.rph + 4'h1;
        if (q.rph == `SNB_MID) begin
          d.rbits = q.rbits + 4'h1;
          if (q.rbits == 4'h0 && rin) begin
            d.rbusy = 1'b0; // false start
          end else if (q.rbits != 4'h0 && q.rbits < nbits - 4'h1) begin
            d.rsh = {rin, q.rsh[8:1]};
          end
        end
        if (frame_end) begin
          d.rbusy = 1'b0;
          // a data read in the same cycle frees the buffer, so the new character still lands
          if (q.rdrf && !rd_data) begin
            d.ovr = 1'b1;
          end else begin
            d.rdata = nine ? q.rsh : {1'b0, q.rsh[8:1]};
            d.rdrf = 1'b1;
            d.fe = !rin;
            d.idle_arm = 1'b1;
          end
        end
      end

      // idle line: one full character time of ones after a received character
      if (q.rbusy || !rin || !q.re) begin
        d.icnt = 4'h0;
        d.iph = 4'h0;
      end else if (tick && q.icnt != nbits) begin
        d.iph = q.iph + 4'h1;
        if (q.iph == `SNB_OSR) begin
          d.icnt = q.icnt + 4'h1;
          if (q.icnt == nbits - 4'h1 && q.idle_arm) begin
            d.idle = 1'b1;
            d.idle_arm = 1'b0;
          end
        end
      end
    end

    // edge detector and bus answer also run in light stop; everything else holds
    if (run || light) begin
      d.rprev = rin;
      if (q.re && rx_fall) begin
        d.edge_f = 1'b1;
      end
    end
    // deep stops drop all register contents; light stop retains them
    if (lose) begin
      d = rst_v;
    end
  end

  // stop modes end shifting: light stop holds the shifter fields of q in d, the deeper stops load reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= rst_v;
    end else begin
      q <= d;
    end
  end

  assign wb_rsp_o.ack = q.ack;
  assign wb_rsp_o.dat = q.rd;

endmodule : snb_serial_port

`default_nettype wire

//--- verif/snb_port_props.sv
// checker for the serial port: bus handshake, pin direction, stop-mode holds
// assumes it is bound to the ports of snb_serial_port
`timescale 1ns/1ns
`default_nettype none
module snb_port_props
  import snb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire snb_wb_req_t wb_req_i,
  input wire snb_wb_rsp_t wb_rsp_o,
  input wire snb_stop_t stop_mode_i,
  input wire logic tx_o,
  input wire logic tx_oe_n_o,
  input wire logic rx_released_o,
  input wire logic wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  sequence light2_s;
    (stop_mode_i == SNB_STOP_LIGHT) [*2];
  endsequence
  ack_answer_a: assert property (req_s |=> wb_rsp_o.ack) else $error("no ack");
  ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack held");
  read_upper_a: assert property (wb_rsp_o.ack && !wb_req_i.we |-> wb_rsp_o.dat[31:16] == 16'h0000)
    else $error("upper bits set");
  duplex_drive_a: assert property (!rx_released_o |-> !tx_oe_n_o) else $error("pin off");
  wake_light_a: assert property (wake_o |-> stop_mode_i == SNB_STOP_LIGHT || $past(stop_mode_i) == SNB_STOP_LIGHT)
    else $error("wake outside light stop");
  deep_lost_a: assert property (stop_mode_i >= SNB_STOP_MID |=> tx_o && !rx_released_o && !wake_o)
    else $error("state kept in deep stop");
  light_hold_a: assert property (light2_s |-> $stable(tx_o) && $stable(tx_oe_n_o))
    else $error("moved in light stop");
  bit_hold_a: assert property (disable iff (rst_i || stop_mode_i >= SNB_STOP_MID) $fell(tx_o) |-> !tx_o [*8])
    else $error("short low bit");
endmodule : snb_port_props
bind snb_serial_port snb_port_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .stop_mode_i(stop_mode_i), .tx_o(tx_o), .tx_oe_n_o(tx_oe_n_o),
  .rx_released_o(rx_released_o), .wake_o(wake_o));
`default_nettype wire

//--- verif/snb_far_dev.sv
// far serial device: sends framed characters on its line
// assumes the port samples on clk_i with BT clocks per bit
`timescale 1ns/1ns
`default_nettype none
module snb_far_dev #(
  parameter int BT = 16
) (
  input wire logic clk_i,
  output logic line_o
);
  initial line_o = 1'b1;
  task automatic send(input logic [8:0] v, input int nb);
    line_o <= 1'b0;
    repeat (BT) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      line_o <= v[i]; // lsb first, ninth bit last
      repeat (BT) @(posedge clk_i);
    end
    line_o <= 1'b1; // stop bit, then the line rests high
    repeat (BT) @(posedge clk_i);
  endtask : send
endmodule : snb_far_dev
`default_nettype wire

//--- verif/snb_serial_port_tb_top.sv
// bench for the serial port: reads queue their expected value, a monitor compares at ack
// assumes the far device model and the checker bind are compiled first
`include "snb_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module snb_serial_port_tb_top
  import snb_pkg::*;
;
  logic clk_i, rst_i, rx_i, lp, pl, txo, oen, rel, wk, t8;
  logic [7:0] d;
  logic [31:0] r, s = 32'h00000033, q[$];
  int miscompares, n_tests, cyc_n;
  snb_wb_req_t req;
  snb_wb_rsp_t rsp;
  snb_stop_t stop;
  wire logic tx_i = oen ? pl : txo; // shared pin: far device drives while port is off
  snb_serial_port u_snb_serial_port (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .stop_mode_i(stop), .rx_i(rx_i), .tx_i(tx_i), .tx_o(txo), .tx_oe_n_o(oen), .rx_released_o(rel), .wake_o(wk));
  snb_far_dev #(.BT(16)) u_far (.clk_i(clk_i), .line_o(pl));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] dat);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: dat};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    r = rsp.dat;
    req <= '0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task automatic poll();
    repeat (400) begin
      wb(1'b0, `SNB_ADR_STAT, 32'h0);
      if (r[`SNB_ST_RDRF]) break;
    end
  endtask : poll
  always @(posedge clk_i) begin
    rx_i <= lp ? ~rx_i : pl; // released pin toggles so any use of it shows
    if (rsp.ack === 1'b1 && !req.we && q.size() > 0) chk(rsp.dat, q.pop_front());
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    rst_i = 1'b1;
    req = '0;
    stop = SNB_RUN;
    lp = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`SNB_ADR_BAUD, 32'h00000082);
    rd(5'h14, 32'h00000000);
    wb(1'b1, `SNB_ADR_BAUD, 32'h00000001); // 16 clocks per bit keeps frames short
    lp <= 1'b1;
    wb(1'b1, `SNB_ADR_CTRL1, 32'h0000000F);
    chk(32'(rel), 32'h1);
    for (int i = 0; i < 3; i++) begin
      t8 = i < 2;
      if (i != 1) wb(1'b1, `SNB_ADR_CTRL3, {31'h0, t8});
      d = 8'(xs());
      wb(1'b1, `SNB_ADR_DATA, {24'h0, d});
      poll();
      rd(`SNB_ADR_CTRL3, {28'h0, t8, 2'b00, t8});
      rd(`SNB_ADR_DATA, {24'h0, d});
    end
    wb(1'b1, `SNB_ADR_CTRL1, 32'h0000001B);
    wb(1'b1, `SNB_ADR_CTRL3, 32'h00000000);
    chk(32'(oen), 32'h1);
    for (int i = 0; i < 2; i++) begin
      d = 8'(xs());
      if (i == 0) u_far.send({1'b0, d}, 8);
      else wb(1'b1, `SNB_ADR_DATA, {24'h0, d});
      poll();
      rd(`SNB_ADR_DATA, {24'h0, d});
      wb(1'b1, `SNB_ADR_CTRL3, 32'h00000002);
      chk(32'(oen), 32'h0);
    end
    lp <= 1'b0;
    wb(1'b1, `SNB_ADR_CTRL1, 32'h00000003);
    chk(32'(rel), 32'h0);
    d = 8'(xs());
    u_far.send({1'b0, d}, 8);
    poll();
    rd(`SNB_ADR_DATA, {24'h0, d});
    repeat (140) @(posedge clk_i);
    wb(1'b0, `SNB_ADR_STAT, 32'h0);
    chk(32'(r[`SNB_ST_IDLE]), 32'h0);
    repeat (30) @(posedge clk_i);
    wb(1'b0, `SNB_ADR_STAT, 32'h0);
    chk(32'(r[`SNB_ST_IDLE]), 32'h1);
    wb(1'b1, `SNB_ADR_STAT, 32'h00000040);
    wb(1'b1, `SNB_ADR_CTRL3, 32'h00000004);
    stop <= SNB_STOP_LIGHT;
    u_far.send(9'h0FF, 8);
    chk(32'(wk), 32'h1);
    stop <= SNB_RUN;
    wb(1'b1, `SNB_ADR_BAUD, 32'h00000005);
    stop <= SNB_STOP_LIGHT; // nothing in flight when entering
    repeat (4) @(posedge clk_i);
    wb(1'b1, `SNB_ADR_BAUD, 32'h00000009); // ignored while stopped
    stop <= SNB_RUN;
    rd(`SNB_ADR_BAUD, 32'h00000005);
    stop <= SNB_STOP_DEEP;
    @(posedge clk_i);
    stop <= SNB_RUN;
    rd(`SNB_ADR_BAUD, 32'h00000082);
    rd(`SNB_ADR_CTRL1, 32'h00000000);
    wb(1'b1, `SNB_ADR_BAUD, 32'h00000005);
    stop <= SNB_STOP_MID;
    @(posedge clk_i);
    stop <= SNB_RUN;
    rd(`SNB_ADR_BAUD, 32'h00000082);
    end_of_test();
  end
endmodule : snb_serial_port_tb_top
`default_nettype wire
